// ### core/adcc_pin_sync.sv
`timescale 1ns/1ns
module adcc_pin_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] pin_raw,
  output logic [7:0] pin_stable
);

  logic [7:0] s1_ff;
  logic [7:0] s2_ff;
  logic [7:0] s3_ff;
  logic [7:0] stable_ff;
  logic [7:0] agree;

  // bits count only once second and third stage agree
  assign agree = ~(s2_ff ^ s3_ff);
  assign pin_stable = stable_ff;

  // three stage synchroniser, first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff <= 8'h00;
      s2_ff <= 8'h00;
      s3_ff <= 8'h00;
      stable_ff <= 8'h00;
    end else begin
      s1_ff <= pin_raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      stable_ff <= (agree & s3_ff) | (~agree & stable_ff);
    end
  end

endmodule

// ### core/adcc_top.sv
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module adcc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire adcc_pkg::adcc_core_res_t core_res,
  output logic conv_start,
  output logic bipolar_select,
  input wire adcc_pkg::adcc_trig_flags_t trig_flags,
  input wire logic [7:0] pin_raw,
  output logic [7:0] port_pin_value,
  output logic [7:0] analog_input_buffer_disable,
  output logic irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ADCC_W_IDLE,
    ADCC_W_HAVE,
    ADCC_W_RESP
  } adcc_wstate_t;

  adcc_wstate_t wstate_ff;
  adcc_wstate_t nxt_wstate;
  logic aw_held_ff;
  logic w_held_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  logic [7:0] ctrl_b_ff;
  logic [7:0] ctrl_a_ff;
  logic [7:0] buf_dis_ff;
  localparam int EV_W_BITS = adcc_pkg::EV_W;
  logic [EV_W_BITS-1:0] irq_stat_ff;
  logic [EV_W_BITS-1:0] irq_mask_ff;
  logic [9:0] result_ff;
  logic lock_ff;
  logic start_ff;
  logic irq_ff;
  logic [7:0] pin_val_ff;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // byte address to register index, flags misaligned as unmapped
  function automatic logic [8:0] decode(input logic [7:0] addr);
    logic [7:0] idx;
    logic ok;
    idx = {2'b00, addr[7:2]};
    ok = (addr[1:0] == 2'b00) &&
         ((idx == adcc_pkg::IDX_BUF_DISABLE) || (idx == adcc_pkg::IDX_CTRL_B) ||
          (idx == adcc_pkg::IDX_RES_LOW) || (idx == adcc_pkg::IDX_RES_HIGH) ||
          (idx == adcc_pkg::IDX_CTRL_A) || (idx == adcc_pkg::IDX_IRQ_STAT) ||
          (idx == adcc_pkg::IDX_IRQ_MASK));
    return {ok, idx};
  endfunction

  // ---------------------------------------------------------------
  // write channel
  // ---------------------------------------------------------------
  logic aw_take;
  logic w_take;
  logic have_aw;
  logic have_w;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_fire;
  logic [8:0] wr_dec;
  logic wr_ok;
  logic [7:0] wr_idx;
  logic [7:0] wr_byte;
  logic wr_lane0;

  assign aw_take = s_axi_awvalid & awready_ff;
  assign w_take = s_axi_wvalid & wready_ff;
  assign have_aw = aw_held_ff | aw_take;
  assign have_w = w_held_ff | w_take;
  assign wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
  assign wr_data = w_held_ff ? wdata_ff : s_axi_wdata;
  assign wr_strb = w_held_ff ? wstrb_ff : s_axi_wstrb;
  assign wr_fire = (wstate_ff != ADCC_W_RESP) & have_aw & have_w;
  assign wr_dec = decode(wr_addr);
  assign wr_ok = wr_dec[8];
  assign wr_idx = wr_dec[7:0];
  assign wr_byte = wr_data[7:0];
  assign wr_lane0 = wr_fire & wr_ok & wr_strb[0];

  // write sequencing: both items may arrive in either order
  always_comb begin
    nxt_wstate = wstate_ff;
    case (wstate_ff)
      ADCC_W_IDLE: begin
        if (wr_fire) begin
          nxt_wstate = ADCC_W_RESP;
        end else if (have_aw | have_w) begin
          nxt_wstate = ADCC_W_HAVE;
        end
      end
      ADCC_W_HAVE: begin
        if (wr_fire) begin
          nxt_wstate = ADCC_W_RESP;
        end
      end
      ADCC_W_RESP: begin
        if (s_axi_bready) begin
          nxt_wstate = ADCC_W_IDLE;
        end
      end
      default: nxt_wstate = ADCC_W_IDLE;
    endcase
  end

  // address and data holding, response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate_ff <= ADCC_W_IDLE;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= adcc_pkg::RESP_OKAY;
    end else begin
      wstate_ff <= nxt_wstate;
      aw_held_ff <= have_aw & ~wr_fire;
      w_held_ff <= have_w & ~wr_fire;
      if (aw_take) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      awready_ff <= (nxt_wstate != ADCC_W_RESP) & ~(have_aw & ~wr_fire);
      wready_ff <= (nxt_wstate != ADCC_W_RESP) & ~(have_w & ~wr_fire);
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? adcc_pkg::RESP_OKAY : adcc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  logic ar_take;
  logic [8:0] rd_dec;
  logic [7:0] rd_idx;
  logic rd_low;
  logic rd_high;
  logic [7:0] res_low_view;
  logic [7:0] res_high_view;
  logic [7:0] rd_byte;

  assign ar_take = s_axi_arvalid & arready_ff;
  assign rd_dec = decode(s_axi_araddr);
  assign rd_idx = rd_dec[7:0];
  assign rd_low = ar_take & rd_dec[8] & (rd_idx == adcc_pkg::IDX_RES_LOW);
  assign rd_high = ar_take & rd_dec[8] & (rd_idx == adcc_pkg::IDX_RES_HIGH);

  // presentation follows the live alignment bit
  assign res_low_view = ctrl_b_ff[adcc_pkg::CB_LEFT_ALIGN] ?
                        {result_ff[1:0], 6'h00} : result_ff[7:0];
  assign res_high_view = ctrl_b_ff[adcc_pkg::CB_LEFT_ALIGN] ?
                         result_ff[9:2] : {6'h00, result_ff[9:8]};

  assign rd_byte = (rd_idx == adcc_pkg::IDX_BUF_DISABLE) ? buf_dis_ff :
                   (rd_idx == adcc_pkg::IDX_CTRL_B) ? ctrl_b_ff :
                   (rd_idx == adcc_pkg::IDX_RES_LOW) ? res_low_view :
                   (rd_idx == adcc_pkg::IDX_RES_HIGH) ? res_high_view :
                   (rd_idx == adcc_pkg::IDX_CTRL_A) ? ctrl_a_ff :
                   (rd_idx == adcc_pkg::IDX_IRQ_STAT) ? {5'h00, irq_stat_ff} :
                   (rd_idx == adcc_pkg::IDX_IRQ_MASK) ? {5'h00, irq_mask_ff} : 8'h00;

  // one read in flight, data captured on address take
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= adcc_pkg::RESP_OKAY;
    end else begin
      if (ar_take) begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rdata_ff <= {24'h000000, rd_dec[8] ? rd_byte : 8'h00};
        rresp_ff <= rd_dec[8] ? adcc_pkg::RESP_OKAY : adcc_pkg::RESP_SLVERR;
      end else if (rvalid_ff) begin
        if (s_axi_rready) begin
          rvalid_ff <= 1'b0;
        end
      end else begin
        arready_ff <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic wr_ctrl_b;
  logic wr_ctrl_a;
  logic wr_buf_dis;
  logic wr_stat;
  logic wr_mask;

  assign wr_ctrl_b = wr_lane0 & (wr_idx == adcc_pkg::IDX_CTRL_B);
  assign wr_ctrl_a = wr_lane0 & (wr_idx == adcc_pkg::IDX_CTRL_A);
  assign wr_buf_dis = wr_lane0 & (wr_idx == adcc_pkg::IDX_BUF_DISABLE);
  assign wr_stat = wr_lane0 & (wr_idx == adcc_pkg::IDX_IRQ_STAT);
  assign wr_mask = wr_lane0 & (wr_idx == adcc_pkg::IDX_IRQ_MASK);

  // software-written registers; start bit is self clearing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_b_ff <= adcc_pkg::CB_RESET;
      ctrl_a_ff <= adcc_pkg::CA_RESET;
      buf_dis_ff <= adcc_pkg::BUF_DIS_RESET;
      irq_mask_ff <= 3'h0;
    end else begin
      // reserved bits stored with the rest
      if (wr_ctrl_b) begin
        ctrl_b_ff <= wr_byte & adcc_pkg::CB_WMASK;
      end
      if (wr_ctrl_a) begin
        ctrl_a_ff <= wr_byte;
      end else begin
        ctrl_a_ff[adcc_pkg::CA_START] <= 1'b0;
      end
      if (wr_buf_dis) begin
        buf_dis_ff <= wr_byte;
      end
      if (wr_mask) begin
        irq_mask_ff <= wr_byte[2:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // trigger and conversion start
  // ---------------------------------------------------------------
  logic trig_rise;
  logic conv_en;
  logic auto_en;
  logic free_run;
  logic auto_start;
  logic nxt_start;

  adcc_trig_edge u_trig (
    .aclk(aclk),
    .aresetn(aresetn),
    .flags(trig_flags),
    .src(ctrl_b_ff[2:0]),
    .rise(trig_rise)
  );

  assign conv_en = ctrl_a_ff[adcc_pkg::CA_CONV_EN];
  assign auto_en = ctrl_a_ff[adcc_pkg::CA_AUTO_EN];
  assign free_run = ctrl_b_ff[2:0] == adcc_pkg::TS_FREE_RUN;
  // source acts only in auto mode and with converter enabled
  assign auto_start = conv_en & auto_en & trig_rise;
  // free running restarts on completion, never on reselection
  assign nxt_start = (conv_en & ctrl_a_ff[adcc_pkg::CA_START]) | auto_start |
                     (conv_en & auto_en & free_run & core_res.done);

  // start pulse to the converter core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_ff <= 1'b0;
    end else begin
      start_ff <= nxt_start;
    end
  end

  // ---------------------------------------------------------------
  // result capture and read lock
  // ---------------------------------------------------------------
  logic take_res;
  logic drop_res;
  logic [9:0] nxt_result;

  assign take_res = core_res.done & ~lock_ff;
  assign drop_res = core_res.done & lock_ff;
  // bipolar keeps two's complement, unipolar saturates when inverted
  assign nxt_result = (~ctrl_b_ff[adcc_pkg::CB_BIPOLAR] & core_res.inverted) ?
                      adcc_pkg::RES_SATURATE : core_res.data;

  // result store and lock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_ff <= 10'h000;
      lock_ff <= 1'b0;
    end else begin
      if (take_res) begin
        result_ff <= nxt_result;
      end
      // low read locks, high read unlocks
      if (rd_high) begin
        lock_ff <= 1'b0;
      end else if (rd_low) begin
        lock_ff <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  logic [2:0] events;
  logic [2:0] nxt_stat;

  assign events = {auto_start, drop_res, take_res};
  // set wins over write-one-to-clear
  assign nxt_stat = (irq_stat_ff & ~({3{wr_stat}} & wr_byte[2:0])) | events;

  // sticky status and level output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_ff <= 3'h0;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_stat;
      irq_ff <= |(nxt_stat & irq_mask_ff);
    end
  end

  // ---------------------------------------------------------------
  // digital input buffers
  // ---------------------------------------------------------------
  logic [7:0] pin_stable;

  adcc_pin_sync u_pins (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_raw(pin_raw),
    .pin_stable(pin_stable)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_val_ff <= 8'h00;
    end else begin
      pin_val_ff <= pin_stable & ~buf_dis_ff;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign conv_start = start_ff;
  assign bipolar_select = ctrl_b_ff[adcc_pkg::CB_BIPOLAR];
  assign port_pin_value = pin_val_ff;
  assign analog_input_buffer_disable = buf_dis_ff;
  assign irq = irq_ff;

endmodule

// ### core/adcc_trig_edge.sv
`timescale 1ns/1ns
module adcc_trig_edge (
  input wire logic aclk,
  input wire logic aresetn,
  input wire adcc_pkg::adcc_trig_flags_t flags,
  input wire logic [2:0] src,
  output logic rise
);

  logic sel;
  logic prev_ff;

  // free running selects a constant low
  assign sel = (src == adcc_pkg::TS_COMPARATOR) ? flags.comparator :
               (src == adcc_pkg::TS_EXT_INT0) ? flags.ext_int0 :
               (src == adcc_pkg::TS_T0_CMP_A) ? flags.t0_cmp_a :
               (src == adcc_pkg::TS_T0_OVF) ? flags.t0_ovf :
               (src == adcc_pkg::TS_T1_CMP_B) ? flags.t1_cmp_b :
               (src == adcc_pkg::TS_T1_OVF) ? flags.t1_ovf :
               (src == adcc_pkg::TS_T1_CAPT) ? flags.t1_capt : 1'b0;

  // edge taken after the mux, so reselection counts
  assign rise = sel & ~prev_ff;

  // last selected level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= sel;
    end
  end

endmodule

// ### inc/adcc_pkg.sv
package adcc_pkg;

  // ---------------------------------------------------------------
  // register indexes, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_BUF_DISABLE = 8'h01;
  localparam logic [7:0] IDX_CTRL_B = 8'h03;
  localparam logic [7:0] IDX_RES_LOW = 8'h04;
  localparam logic [7:0] IDX_RES_HIGH = 8'h05;
  localparam logic [7:0] IDX_CTRL_A = 8'h06;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h07;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h08;
  localparam int ADDR_W = 8;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int CB_BIPOLAR = 7;
  localparam int CB_LEFT_ALIGN = 4;
  localparam logic [7:0] CB_RESET = 8'h00;
  localparam logic [7:0] CB_WMASK = 8'hFF; // bits 6, 5 and 3 plain storage
  localparam int CA_CONV_EN = 0;
  localparam int CA_AUTO_EN = 1;
  localparam int CA_START = 2;
  localparam logic [7:0] CA_RESET = 8'h00;
  localparam logic [7:0] BUF_DIS_RESET = 8'h00;
  localparam int EV_DONE = 0;
  localparam int EV_DROP = 1;
  localparam int EV_TRIG = 2;
  localparam int EV_W = 3;
  localparam logic [9:0] RES_SATURATE = 10'h3FF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // trigger source encodings
  // ---------------------------------------------------------------
  localparam logic [2:0] TS_FREE_RUN = 3'h0;
  localparam logic [2:0] TS_COMPARATOR = 3'h1;
  localparam logic [2:0] TS_EXT_INT0 = 3'h2;
  localparam logic [2:0] TS_T0_CMP_A = 3'h3;
  localparam logic [2:0] TS_T0_OVF = 3'h4;
  localparam logic [2:0] TS_T1_CMP_B = 3'h5;
  localparam logic [2:0] TS_T1_OVF = 3'h6;
  localparam logic [2:0] TS_T1_CAPT = 3'h7;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic done;       // one-cycle pulse, conversion finished
    logic inverted;   // positive input not above negative input
    logic [9:0] data; // raw code, two's complement in bipolar mode
  } adcc_core_res_t;

  typedef struct packed {
    logic t1_capt;
    logic t1_ovf;
    logic t1_cmp_b;
    logic t0_ovf;
    logic t0_cmp_a;
    logic ext_int0;
    logic comparator;
  } adcc_trig_flags_t;

endpackage

// ### tb/adcc_core_model.sv
`timescale 1ns/1ns
module adcc_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic conv_start,
  input wire logic [3:0] lat,
  input wire logic [9:0] code,
  input wire logic inv,
  output adcc_pkg::adcc_core_res_t core_res
);
  logic [3:0] cnt_ff;
  // conversion timer; data lines toggle outside the done pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= 4'h0;
      core_res <= '0;
    end else if (cnt_ff == 4'h1 && !conv_start) begin
      cnt_ff <= 4'h0;
      core_res <= {1'b1, inv, code};
    end else begin
      cnt_ff <= conv_start ? lat : cnt_ff - {3'h0, cnt_ff != 4'h0};
      core_res.done <= 1'b0;
      core_res.data <= ~core_res.data;
    end
  end
endmodule

// ### tb/adcc_top_asserts.sv
`timescale 1ns/1ns
module adcc_top_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic conv_start,
  input wire logic bipolar_select,
  input wire logic [7:0] port_pin_value,
  input wire logic [7:0] analog_input_buffer_disable
);
  // bus handshakes seen at an edge
  wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire rd_take = s_axi_arvalid && s_axi_arready;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  write_answer_a: assert property (wr_take |=> s_axi_bvalid)
    else $error("write response late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  read_answer_a: assert property (rd_take |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000)
    else $error("read response late or wide");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  unmapped_read_a: assert property (rd_take && s_axi_araddr == 8'h24 |=>
    s_axi_rresp == adcc_pkg::RESP_SLVERR && s_axi_rdata == 32'h00000000)
    else $error("unmapped read answered");
  bipolar_write_a: assert property (
    wr_take && s_axi_awaddr == 8'h0C && s_axi_wstrb[0] |=>
    bipolar_select == $past(s_axi_wdata[7]))
    else $error("bipolar select not written");
  disable_write_a: assert property (
    wr_take && s_axi_awaddr == 8'h04 && s_axi_wstrb[0] |=>
    analog_input_buffer_disable == $past(s_axi_wdata[7:0]))
    else $error("disable register not written");
  pin_forced_a: assert property (
    $stable(analog_input_buffer_disable) [*6] |->
    (port_pin_value & analog_input_buffer_disable) == 8'h00)
    else $error("disabled pin reads one");
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
endmodule
bind adcc_top adcc_top_asserts u_chk (.*);

// ### tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic aclk, aresetn, inv, conv_start, bipolar_select, irq;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, pin_raw, port_pin_value, analog_input_buffer_disable;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, v;
  logic [3:0] s_axi_wstrb, lat;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [9:0] code, r1;
  adcc_pkg::adcc_core_res_t core_res;
  adcc_pkg::adcc_trig_flags_t trig_flags;
  int bad_count, check_count, starts, n0;
  adcc_top u_dut (.*);
  adcc_core_model u_core (.aclk(aclk), .aresetn(aresetn), .conv_start(conv_start), .lat(lat),
    .code(code), .inv(inv), .core_res(core_res));
  // ---------------------------------------------------------------
  // clock, start counter, watchdog
  // ---------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) if (conv_start === 1'b1) starts <= starts + 1;
  initial begin
    #800000;
    bad_count++;
    close_out();
  end
  // ---------------------------------------------------------------
  // tasks and expectations
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // response side may lag, so the slave must hold its answer
    s_axi_bready <= 1'($urandom);
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
    s_axi_bready <= 1'b0;
    rr = s_axi_bresp;
    if (n >= 50) bad_count++;
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'($urandom);
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    if (n >= 50) bad_count++;
  endtask
  // clear status, start by software, wait for the interrupt
  task automatic conv(input logic [9:0] c, input logic iv);
    int n;
    wr(8'h1C, 32'h7);
    code <= c;
    inv <= iv;
    lat <= 4'(2 + $urandom % 7);
    wr(8'h18, 32'h5);
    n = 0;
    while (irq !== 1'b1 && n < 40) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 40) bad_count++;
  endtask
  function automatic logic [9:0] res_of(input logic [9:0] c, input logic iv, input logic bp);
    return (!bp && iv) ? 10'h3FF : c;
  endfunction
  function automatic logic [31:0] lo_of(input logic [9:0] r, input logic left);
    return left ? {24'h0, r[1:0], 6'h0} : {24'h0, r[7:0]};
  endfunction
  function automatic logic [31:0] hi_of(input logic [9:0] r, input logic left);
    return left ? {24'h0, r[9:2]} : {30'h0, r[9:8]};
  endfunction
  // low byte first, then high byte
  task automatic pair(input logic [9:0] r, input logic left);
    rdr(8'h10);
    chk(rd, lo_of(r, left));
    rdr(8'h14);
    chk(rd, hi_of(r, left));
  endtask
  task automatic close_out();
    $display("comparisons=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    v = $urandom(56223);
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    {pin_raw, trig_flags, code, inv} = '0;
    s_axi_wstrb = 4'hF;
    lat = 4'h3;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset values and an unmapped place
    rdr(8'h04);
    chk(rd, 32'h0);
    rdr(8'h0C);
    chk(rd, 32'h0);
    rdr(8'h24);
    chk({30'h0, rr}, {30'h0, adcc_pkg::RESP_SLVERR});
    wr(8'h24, 32'hFF);
    chk({30'h0, rr}, {30'h0, adcc_pkg::RESP_SLVERR});
    // control b storage incl. reserved bits
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 32'h28 : {24'h0, 8'($urandom)};
      wr(8'h0C, v);
      rdr(8'h0C);
      chk(rd, v);
      chk({31'h0, bipolar_select}, {31'h0, v[7]});
    end
    // disable bits force pin reads to zero
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      pin_raw <= v[15:8];
      wr(8'h04, {24'h0, v[7:0]});
      repeat (8) @(posedge aclk);
      chk({24'h0, port_pin_value}, {24'h0, v[15:8] & ~v[7:0]});
      chk({24'h0, analog_input_buffer_disable}, {24'h0, v[7:0]});
    end
    // software conversions in both polarity modes, inverted and not, both alignments read live
    wr(8'h20, 32'h3);
    for (int i = 0; i < 4; i++) begin
      r1 = 10'($urandom);
      wr(8'h0C, {24'h0, i[1], 7'h0});
      conv(r1, i[0]);
      r1 = res_of(r1, i[0], i[1]);
      pair(r1, 1'b0);
      wr(8'h0C, {24'h0, i[1], 2'h0, 1'b1, 4'h0});
      pair(r1, 1'b1);
    end
    // lock after low read, drop while locked
    rdr(8'h10);
    conv(10'($urandom), 1'b0);
    rdr(8'h1C);
    chk(rd, 32'h2);
    rdr(8'h14);
    chk(rd, hi_of(r1, 1'b1));
    pair(r1, 1'b1);
    // masked interrupt, then unmask and clear
    wr(8'h20, 32'h0);
    wr(8'h1C, 32'h7);
    wr(8'h18, 32'h5);
    repeat (15) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    wr(8'h20, 32'h1);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    wr(8'h1C, 32'h1);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    // every trigger source except free running, selected and unselected flags
    wr(8'h18, 32'h3);
    for (int s = 1; s < 8; s++) begin
      wr(8'h0C, s);
      n0 = starts;
      trig_flags <= 7'(1 << (s % 7));
      repeat (4) @(posedge aclk);
      chk(starts - n0, 0);
      trig_flags <= 7'(1 << (s - 1));
      repeat (4) @(posedge aclk);
      chk(starts - n0, 1);
      trig_flags <= 7'h00;
      repeat (12) @(posedge aclk);
    end
    // switching onto a set flag, then to free running
    trig_flags <= 7'h02;
    wr(8'h0C, 32'h1);
    n0 = starts;
    wr(8'h0C, 32'h2);
    repeat (4) @(posedge aclk);
    chk(starts - n0, 1);
    repeat (12) @(posedge aclk);
    n0 = starts;
    wr(8'h0C, 32'h0);
    repeat (10) @(posedge aclk);
    chk(starts - n0, 0);
    // free running keeps restarting after a software start
    n0 = starts;
    wr(8'h18, 32'h7);
    repeat (30) @(posedge aclk);
    chk({31'h0, (starts - n0) > 2}, 32'h1);
    // auto trigger off: the field has no effect
    wr(8'h18, 32'h1);
    wr(8'h0C, 32'h3);
    n0 = starts;
    trig_flags <= 7'h04;
    repeat (6) @(posedge aclk);
    chk(starts - n0, 0);
    close_out();
  end
endmodule
